// File: hw/delay_timer.sv
// Restart delay timer that raises done after a run of enabled cycles.
`timescale 1ns/100ps
module delay_timer
  #(parameter int unsigned CYCLES = 500)
  (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Control
  input  wire logic run,
  // Status
  output logic      done
  );

  localparam int unsigned WIDTH = $clog2(CYCLES + 1);

  logic [WIDTH-1:0] count;

  if (CYCLES < 1) begin : cycles_check
    $error("delay_timer needs at least one cycle");
  end

  // ****************************************
  // Counter
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      count <= '0;
      done  <= 1'b0;
    end else if (count == WIDTH'(CYCLES - 1)) begin
      done <= 1'b1;
    end else begin
      count <= count + WIDTH'(1);
    end
  end

endmodule : delay_timer

// File: hw/supply_mode_pkg.sv
// Package with mode encodings, timing constants and frame layout for the supply mode machine.
package supply_mode_pkg;

  // ****************************************
  // Mode encodings
  // ****************************************
  typedef enum logic [2:0] {
    mode_init      = 3'b000,
    mode_normal    = 3'b001,
    mode_stop      = 3'b010,
    mode_sleep     = 3'b011,
    mode_restart   = 3'b100,
    mode_fail_safe = 3'b101
  } mode_type;

  localparam int unsigned MODE_COUNT = 6;

  // ****************************************
  // Mode field values written by the host
  // ****************************************
  localparam logic [1:0] REQ_NORMAL = 2'h0;
  localparam logic [1:0] REQ_SLEEP  = 2'h1;
  localparam logic [1:0] REQ_STOP   = 2'h2;
  localparam logic [1:0] REQ_RESET  = 2'h3;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int unsigned FRAME_BITS     = 16;
  localparam int unsigned FRAME_MODE_LSB = 14;
  localparam int unsigned FRAME_MODE_MSB = 15;
  localparam int unsigned FRAME_WRITE    = 7;
  localparam logic [6:0]  MODE_CTRL_ADDR = 7'h01;
  localparam logic [2:0]  MODE_FIELD_RESET = 3'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLOCK_HZ             = 50_000_000;
  localparam int unsigned RESTART_DELAY_US     = 10;
  localparam int unsigned RESTART_DELAY_CYCLES =
    (RESTART_DELAY_US * (CLOCK_HZ / 1_000_000) > 0) ?
    RESTART_DELAY_US * (CLOCK_HZ / 1_000_000) : 1;

endpackage : supply_mode_pkg

// File: hw/supply_mode_state_machine.sv
// Operating mode state machine sequencing init, normal, stop, sleep, restart and fail-safe.
//
// Contract
// - Six modes exist: init, normal, stop, sleep, restart, fail-safe.
// - Init is entered at power-up and on a soft reset request.
// - Stop keeps the main regulator output enabled.
// - Sleep disables the main regulator output.
// - A wake in sleep, or in fail-safe with overtemperature cleared, leads to restart.
// - Watchdog failure or regulator undervoltage in normal or stop leads to restart.
// - Restart drives reset to the microcontroller.
// - Restart moves to normal after the delay once failures clear.
// - Level two thermal shutdown or regulator short leads to fail-safe.
// - Fail-safe keeps regulator off and holds without leaving alone.
// - Fail-safe exits only on wake with overtemperature cleared.
// - Development mode halts the watchdog counter.
// - Strap held low during init selects development mode.
// - Development mode still reaches every operating mode.
// - Host talks through sixteen-bit frames.
// - Mode field clears when passing through restart.
// - Mode field reads back the current mode.
// - Any frame in init after the delay has run out moves to normal.
// - Stop to sleep request flags a command error and restarts.
// - Init releases reset after the delay once regulator is above threshold.
`timescale 1ns/100ps
module supply_mode_state_machine
  import supply_mode_pkg::*;
  #(parameter int unsigned RESTART_CYCLES = RESTART_DELAY_CYCLES)
  (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Host frame port
  input  wire logic        frame_valid,
  input  wire logic [15:0] frame_data,
  // Supervision inputs
  input  wire logic        wake_event,
  input  wire logic        watchdog_fail,
  input  wire logic        regulator_undervoltage,
  input  wire logic        regulator_above_threshold,
  input  wire logic        thermal_shutdown_level_two,
  input  wire logic        regulator_short,
  input  wire logic        overtemperature,
  input  wire logic        strap_low,
  // Outputs
  output mode_type         mode,
  output logic [2:0]       mode_field,
  output logic             main_regulator_output,
  output logic             mcu_reset_n,
  output logic             development_mode,
  output logic             watchdog_halt,
  output logic             command_error
  );

  mode_type   next_mode;
  logic       delay_run;
  logic       delay_done;
  logic       is_write;
  logic [1:0] req;
  logic       failure;
  logic       critical;

  // ****************************************
  // Elaboration check
  // ****************************************
  if (RESTART_CYCLES < 1) begin : cycles_check
    $error("RESTART_CYCLES must be at least one");
  end

  // ****************************************
  // Frame decode
  // ****************************************
  function automatic logic mode_write(input logic [15:0] f);
    return f[FRAME_WRITE] && (f[FRAME_WRITE-1:0] == MODE_CTRL_ADDR);
  endfunction : mode_write

  assign is_write = frame_valid && mode_write(frame_data);
  assign req      = frame_data[FRAME_MODE_MSB:FRAME_MODE_LSB];
  assign failure  = watchdog_fail || regulator_undervoltage;
  assign critical = thermal_shutdown_level_two || regulator_short;

  // ****************************************
  // Restart delay timer
  // ****************************************
  assign delay_run = (mode == mode_restart && !failure)
                   || (mode == mode_init && regulator_above_threshold);

  delay_timer #(.CYCLES(RESTART_CYCLES)) restart_timer (
    .clk   (clk),
    .reset (reset),
    .run   (delay_run),
    .done  (delay_done)
  );

  // ****************************************
  // Next mode
  // ****************************************
  always_comb begin
    next_mode = mode;
    case (mode)
      mode_init: begin
        if (frame_valid && delay_done) begin
          next_mode = mode_normal;
        end
      end
      mode_normal: begin
        if (is_write) begin
          case (req)
            REQ_STOP:  next_mode = mode_stop;
            REQ_SLEEP: next_mode = mode_sleep;
            REQ_RESET: next_mode = mode_init;
            default:   next_mode = mode;
          endcase
        end
      end
      mode_stop: begin
        if (is_write) begin
          case (req)
            REQ_NORMAL: next_mode = mode_normal;
            REQ_SLEEP:  next_mode = mode_restart;
            REQ_RESET:  next_mode = mode_init;
            default:    next_mode = mode;
          endcase
        end
      end
      mode_sleep: begin
        if (wake_event) begin
          next_mode = mode_restart;
        end
      end
      mode_restart: begin
        if (delay_done && !failure) begin
          next_mode = mode_normal;
        end
      end
      mode_fail_safe: begin
        if (wake_event && !overtemperature) begin
          next_mode = mode_restart;
        end
      end
      default: next_mode = mode_init;
    endcase
    if (critical) begin
      next_mode = mode_fail_safe;
    end else if (failure && (mode == mode_normal || mode == mode_stop)) begin
      next_mode = mode_restart;
    end
  end

  // ****************************************
  // Mode register
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      mode <= mode_init;
    end else begin
      mode <= next_mode;
    end
  end

  // ****************************************
  // Mode field read back
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_field <= MODE_FIELD_RESET;
    end else if (next_mode == mode_restart) begin
      mode_field <= MODE_FIELD_RESET;
    end else begin
      mode_field <= next_mode;
    end
  end

  // ****************************************
  // Supply and reset outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      main_regulator_output <= 1'b1;
      mcu_reset_n           <= 1'b0;
    end else begin
      main_regulator_output <= !(next_mode == mode_sleep
                                || next_mode == mode_fail_safe);
      mcu_reset_n <= !(next_mode == mode_restart
                      || (next_mode == mode_init && !delay_done));
    end
  end

  // ****************************************
  // Development mode
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      development_mode <= 1'b0;
      watchdog_halt    <= 1'b0;
    end else begin
      if (mode == mode_init) begin
        development_mode <= strap_low;
      end
      watchdog_halt <= (mode == mode_init) ? strap_low : development_mode;
    end
  end

  // ****************************************
  // Command error flag
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      command_error <= 1'b0;
    end else if (mode == mode_stop && is_write && req == REQ_SLEEP) begin
      command_error <= 1'b1;
    end else if (is_write && mode == mode_normal) begin
      command_error <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence stop_to_sleep_s;
    mode == mode_stop && is_write && req == REQ_SLEEP && !critical;
  endsequence

  sequence fail_safe_wake_s;
    mode == mode_fail_safe && wake_event && !overtemperature && !critical;
  endsequence

  sequence restart_ready_s;
    mode == mode_restart && delay_done && !failure && !critical;
  endsequence

  sequence running_failure_s;
    (mode == mode_normal || mode == mode_stop) && failure && !critical;
  endsequence

  sequence normal_write_s;
    mode == mode_normal && is_write && !failure && !critical;
  endsequence

  sleep_regulator_off_a: assert property (@(posedge clk) disable iff (reset)
    mode == mode_sleep |-> !main_regulator_output)
    else $error("regulator on in sleep");

  stop_regulator_on_a: assert property (@(posedge clk) disable iff (reset)
    mode == mode_stop |-> main_regulator_output)
    else $error("regulator off in stop");

  restart_reset_a: assert property (@(posedge clk) disable iff (reset)
    mode == mode_restart |-> !mcu_reset_n)
    else $error("reset not driven in restart");

  sleep_wake_a: assert property (@(posedge clk) disable iff (reset)
    mode == mode_sleep && wake_event && !critical |=> mode == mode_restart)
    else $error("wake in sleep missed");

  sleep_hold_a: assert property (@(posedge clk) disable iff (reset)
    mode == mode_sleep && !wake_event && !critical |=> mode == mode_sleep)
    else $error("sleep left without wake");

  stop_sleep_a: assert property (@(posedge clk) disable iff (reset)
    stop_to_sleep_s |=> mode == mode_restart && command_error)
    else $error("stop to sleep not refused");

  error_sticky_a: assert property (@(posedge clk) disable iff (reset)
    command_error && !(mode == mode_normal && is_write) |=> command_error)
    else $error("command error lost");

  critical_fail_a: assert property (@(posedge clk) disable iff (reset)
    critical |=> mode == mode_fail_safe)
    else $error("critical failure missed");

  fail_safe_hold_a: assert property (@(posedge clk) disable iff (reset)
    mode == mode_fail_safe && !wake_event |=> mode == mode_fail_safe)
    else $error("fail-safe left alone");

  fail_safe_supply_a: assert property (@(posedge clk) disable iff (reset)
    mode == mode_fail_safe |-> !main_regulator_output)
    else $error("regulator on in fail-safe");

  fail_safe_exit_a: assert property (@(posedge clk) disable iff (reset)
    fail_safe_wake_s |=> mode == mode_restart)
    else $error("fail-safe wake missed");

  fail_safe_hot_a: assert property (@(posedge clk) disable iff (reset)
    mode == mode_fail_safe && overtemperature |=> mode == mode_fail_safe)
    else $error("fail-safe left while hot");

  failure_restart_a: assert property (@(posedge clk) disable iff (reset)
    running_failure_s |=> mode == mode_restart)
    else $error("failure did not restart");

  restart_hold_a: assert property (@(posedge clk) disable iff (reset)
    mode == mode_restart && failure && !critical |=> mode == mode_restart)
    else $error("restart left during failure");

  restart_exit_a: assert property (@(posedge clk) disable iff (reset)
    restart_ready_s |=> mode == mode_normal && mcu_reset_n)
    else $error("restart exit missed");

  init_reset_a: assert property (@(posedge clk) disable iff (reset)
    mode == mode_init && !delay_done && !critical |=> !mcu_reset_n)
    else $error("reset released early in init");

  soft_reset_a: assert property (@(posedge clk) disable iff (reset)
    normal_write_s ##0 req == REQ_RESET |=> mode == mode_init)
    else $error("soft reset missed");

  normal_stop_a: assert property (@(posedge clk) disable iff (reset)
    normal_write_s ##0 req == REQ_STOP |=> mode == mode_stop)
    else $error("stop request missed");

  normal_keep_a: assert property (@(posedge clk) disable iff (reset)
    normal_write_s ##0 req == REQ_NORMAL |=> mode == mode_normal)
    else $error("normal request changed mode");

  strap_latch_a: assert property (@(posedge clk) disable iff (reset)
    mode == mode_init && strap_low |=> development_mode)
    else $error("strap low not latched");

  strap_clear_a: assert property (@(posedge clk) disable iff (reset)
    mode == mode_init && !strap_low |=> !development_mode)
    else $error("strap high not latched");

  dev_hold_a: assert property (@(posedge clk) disable iff (reset)
    mode != mode_init |=> $stable(development_mode))
    else $error("development mode changed outside init");

  dev_halt_a: assert property (@(posedge clk) disable iff (reset)
    development_mode |-> watchdog_halt)
    else $error("watchdog not halted");

  field_restart_a: assert property (@(posedge clk) disable iff (reset)
    mode == mode_restart |-> mode_field == MODE_FIELD_RESET)
    else $error("mode field not cleared");

  field_track_a: assert property (@(posedge clk) disable iff (reset)
    mode != mode_restart |-> mode_field == mode)
    else $error("mode field does not match mode");

  init_frame_a: assert property (@(posedge clk) disable iff (reset)
    mode == mode_init && frame_valid && delay_done && !critical
    |=> mode == mode_normal)
    else $error("init frame ignored");

endmodule : supply_mode_state_machine

// File: test/host_model.sv
// Host model that hands complete frames to the mode machine.
`timescale 1ns/100ps
module host_model
  (
  // Clock
  input  wire logic        clk,
  // Bench request
  input  wire logic        send,
  input  wire logic [15:0] word,
  // Frame port
  output logic             frame_valid,
  output logic [15:0]      frame_data
  );
  initial begin
    frame_valid = 1'b0;
    frame_data  = 16'h0000;
  end
  // Each request leaves as one whole frame; between frames the data toggles.
  always @(posedge clk) begin
    frame_valid <= send;
    frame_data  <= send ? word : ~frame_data;
  end
endmodule : host_model

// File: test/supply_mode_state_machine_test.sv
// Self-checking bench for the supply mode machine.
`timescale 1ns/100ps
module supply_mode_state_machine_test;
  import supply_mode_pkg::*;
  localparam int unsigned RC = 4;
  localparam int LIMIT = 3000;
  logic clk = 1'b0, reset = 1'b1, send = 1'b0, wake = 1'b0, wd = 1'b0, uv = 1'b0;
  logic above = 1'b0, tsd = 1'b0, shrt = 1'b0, otemp = 1'b0, strap = 1'b1;
  logic [15:0] word = 16'h0000, fdata;
  logic fvalid, reg_on, rst_n, dev, halt, cerr;
  logic [2:0] mfield;
  mode_type mode;
  int n_errors = 0, cmp_count = 0, cycles = 0;

  always #10 clk = ~clk;

  host_model host (.clk(clk), .send(send), .word(word), .frame_valid(fvalid),
                   .frame_data(fdata));

  supply_mode_state_machine #(.RESTART_CYCLES(RC)) dut (
    .clk(clk), .reset(reset), .frame_valid(fvalid), .frame_data(fdata),
    .wake_event(wake), .watchdog_fail(wd), .regulator_undervoltage(uv),
    .regulator_above_threshold(above), .thermal_shutdown_level_two(tsd),
    .regulator_short(shrt), .overtemperature(otemp), .strap_low(strap),
    .mode(mode), .mode_field(mfield), .main_regulator_output(reg_on),
    .mcu_reset_n(rst_n), .development_mode(dev), .watchdog_halt(halt),
    .command_error(cerr));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic end_sim;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      $display("ERROR timeout expected below %0d seen %0d", LIMIT, cycles);
      end_sim();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [2:0] field_of(input mode_type m);
    return (m == mode_restart) ? 3'h0 : 3'(m);
  endfunction : field_of

  function automatic logic supply_of(input mode_type m);
    return !(m == mode_sleep || m == mode_fail_safe);
  endfunction : supply_of

  task automatic state(input mode_type m);
    chk("mode", 3'(m), 3'(mode));
    chk("mode_field", field_of(m), mfield);
    chk("regulator", {2'h0, supply_of(m)}, {2'h0, reg_on});
    chk("mcu_reset_n", {2'h0, m != mode_restart}, {2'h0, rst_n});
  endtask : state

  task automatic frame(input logic [15:0] w);
    @(posedge clk);
    send <= 1'b1;
    word <= w;
    @(posedge clk);
    send <= 1'b0;
    cyc(3);
  endtask : frame

  task automatic put(input logic [1:0] code);
    frame({code, 6'h00, 1'b1, MODE_CTRL_ADDR});
  endtask : put

  task automatic wk;
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    cyc(1);
  endtask : wk

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hD14D));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    cyc(2);
    chk("mode", 3'(mode_init), 3'(mode));
    chk("mcu_reset_n", 3'h0, {2'h0, rst_n});
    @(posedge clk);
    above <= 1'b1;
    cyc(RC + 3);
    chk("mcu_reset_n", 3'h1, {2'h0, rst_n});
    chk("development_mode", 3'h1, {2'h0, dev});
    chk("watchdog_halt", 3'h1, {2'h0, halt});
    frame(16'($urandom()));
    state(mode_normal);
    put(REQ_STOP);
    state(mode_stop);
    put(REQ_SLEEP);
    state(mode_restart);
    chk("command_error", 3'h1, {2'h0, cerr});
    cyc(RC + 3);
    state(mode_normal);
    put(REQ_SLEEP);
    state(mode_sleep);
    chk("command_error", 3'h0, {2'h0, cerr});
    wk();
    state(mode_restart);
    cyc(RC + 3);
    state(mode_normal);
    @(posedge clk);
    uv <= 1'b1;
    cyc(RC + 3 + int'($urandom_range(6)));
    state(mode_restart);
    @(posedge clk);
    uv <= 1'b0;
    cyc(RC + 3);
    state(mode_normal);
    frame({2'($urandom()), 6'h00, 1'b1, 7'h02});
    frame({2'($urandom()), 6'h00, 1'b0, MODE_CTRL_ADDR});
    state(mode_normal);
    put(REQ_NORMAL);
    state(mode_normal);
    put(REQ_STOP);
    state(mode_stop);
    @(posedge clk);
    wd <= 1'b1;
    cyc(2);
    state(mode_restart);
    @(posedge clk);
    wd <= 1'b0;
    cyc(RC + 3);
    state(mode_normal);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      tsd <= (i == 0);
      shrt <= (i == 1);
      otemp <= 1'b1;
      cyc(2);
      state(mode_fail_safe);
      @(posedge clk);
      tsd <= 1'b0;
      shrt <= 1'b0;
      cyc(2 + int'($urandom_range(8)));
      state(mode_fail_safe);
      wk();
      state(mode_fail_safe);
      @(posedge clk);
      otemp <= 1'b0;
      cyc(3);
      state(mode_fail_safe);
      wk();
      state(mode_restart);
      cyc(RC + 3);
      state(mode_normal);
    end
    put(REQ_RESET);
    chk("mode", 3'(mode_init), 3'(mode));
    chk("mcu_reset_n", 3'h0, {2'h0, rst_n});
    @(posedge clk);
    strap <= 1'b0;
    cyc(RC + 3);
    chk("development_mode", 3'h0, {2'h0, dev});
    chk("mcu_reset_n", 3'h1, {2'h0, rst_n});
    frame(16'($urandom()));
    state(mode_normal);
    chk("watchdog_halt", 3'h0, {2'h0, halt});
    end_sim();
  end
endmodule : supply_mode_state_machine_test
